/* File: mode_ctrl_pkg.sv */
// package: register map, field positions, reset values and timing counts
package mode_ctrl_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [11:0] basic_mode_control_off = 12'h000;
  localparam logic [11:0] link_status_off = 12'h004;
  localparam logic [11:0] event_status_off = 12'h008;
  localparam logic [11:0] fixed_info_off = 12'h00c;
  localparam logic [11:0] reset_time_off = 12'h010;
  // ------------------------------------------------------------
  // basic_mode_control fields
  // ------------------------------------------------------------
  localparam int sw_reset_bit = 15;
  localparam int loopback_bit = 14;
  localparam int speed_bit = 13;
  localparam int autoneg_bit = 12;
  localparam int power_down_bit = 11;
  localparam int duplex_bit = 8;
  localparam logic [15:0] control_write_mask = 16'h7900;
  // ------------------------------------------------------------
  // event_status fields
  // ------------------------------------------------------------
  localparam int rx_err_count_lsb = 0;
  localparam int rx_err_count_w = 8;
  localparam int link_fail_bit = 8;
  localparam int link_up_latched_bit = 9;
  // ------------------------------------------------------------
  // fixed values (arbitrary neutral value)
  // ------------------------------------------------------------
  localparam logic [15:0] fixed_info_value = 16'h0a5c;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int clk_mhz = 250;
  localparam int sw_reset_ns = 1000;
  localparam logic [15:0] sw_reset_cycles = 16'((sw_reset_ns * clk_mhz) / 1000);
  localparam int loopback_dead_us = 500;
  localparam logic [31:0] loopback_dead_cycles = 32'(loopback_dead_us * clk_mhz);
  // ------------------------------------------------------------
  // bus answers
  // ------------------------------------------------------------
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
endpackage : mode_ctrl_pkg

/* File: sync2.sv */
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module sync2 (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // level
  input wire logic i_d,
  output logic o_q
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = i_d;
    next_q = meta;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta <= next_meta;
      o_q <= next_q;
    end
  end
endmodule : sync2

/* File: reset_timer.sv */
// software reset sequencer: busy while counting down
`timescale 1ns/1ps
module reset_timer
  import mode_ctrl_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_start,
  input wire logic [15:0] i_cycles,
  output logic o_busy,
  output logic o_done
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic next_busy;
  logic next_done;

  always_comb begin
    next_count = count;
    next_busy = o_busy;
    next_done = 1'b0;
    if (i_start && !o_busy) begin
      next_busy = 1'b1;
      next_count = (i_cycles == 16'h0000) ? 16'h0001 : i_cycles;
    end else if (o_busy) begin
      if (count == 16'h0001) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_count = 16'h0000;
      end else begin
        next_count = count - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count <= 16'h0000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      count <= next_count;
      o_busy <= next_busy;
      o_done <= next_done;
    end
  end
endmodule : reset_timer

/* File: basic_mode_control_reg.sv */
// basic mode control register bank with status registers on axi4-lite
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - a read-only clear-after-read field returns its value on read and then clears to zero; here an error pulse in the read cycle still counts, leaving one.
// - a latched-high bit goes to one on its event and holds until its register is read.
// - a latched-low bit goes to zero on its event and holds zero until its register is read.
// - a self-clearing bit sets on its event and clears itself when the event ends.
// - read-only fixed fields always return their fixed value and ignore writes.
// - writing one to bit 15 starts a software reset that reads one until done, reset value 0.
// - a software reset re-samples the straps so strapped fields take their strap values again.
// - bit 14 set routes mii transmit data into the mii receive path, resets to 0.
// - with auto-negotiation off, bit 13 picks 100 Mb/s (one) or 10 Mb/s (zero), strap default.
// - bit 12 auto-negotiation enable resets from its strap and stays writable.
// - with auto-negotiation on, bits 8 and 13 are ignored; off, they alone set duplex and speed.
// - bit 11 set powers down everything but the register block, resets to 0; with bit 14 also set, loopback still drives o_mii_rxd.
// - with auto-negotiation off, bit 8 picks full (one) or half (zero) duplex, strap default.
module basic_mode_control_reg
  import mode_ctrl_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [11:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [11:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // strap pins
  input wire logic i_strap_speed,
  input wire logic i_strap_autoneg,
  input wire logic i_strap_duplex,
  // status events from the phy core
  input wire logic i_rx_err_pulse,
  input wire logic i_link_ok,
  // mii data path
  input wire logic [3:0] i_mii_txd,
  input wire logic i_mii_tx_en,
  input wire logic [3:0] i_line_rxd,
  input wire logic i_line_rx_dv,
  output logic [3:0] o_mii_rxd,
  output logic o_mii_rx_dv,
  // operating mode to the phy core
  output logic o_speed_100,
  output logic o_full_duplex,
  output logic o_autoneg_en,
  output logic o_power_down,
  output logic o_core_reset,
  output logic o_loopback_settling
);
  // ------------------------------------------------------------
  // strap synchronisers
  // ------------------------------------------------------------
  logic strap_speed_s;
  logic strap_autoneg_s;
  logic strap_duplex_s;
  sync2 u_sync_speed (.i_clk(i_clk), .i_nrst(i_nrst), .i_d(i_strap_speed), .o_q(strap_speed_s));
  sync2 u_sync_an (.i_clk(i_clk), .i_nrst(i_nrst), .i_d(i_strap_autoneg), .o_q(strap_autoneg_s));
  sync2 u_sync_dup (.i_clk(i_clk), .i_nrst(i_nrst), .i_d(i_strap_duplex), .o_q(strap_duplex_s));

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ------------------------------------------------------------
  // bus handshake state
  // ------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [11:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_write;
  logic do_read;

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [15:0] control;
  logic [15:0] next_control;
  logic [1:0] strap_age;
  logic [1:0] next_strap_age;
  logic [15:0] reset_len;
  logic [15:0] next_reset_len;
  logic [7:0] rx_err_count;
  logic [7:0] next_rx_err_count;
  logic link_fail_latched;
  logic next_link_fail_latched;
  logic link_up_latched;
  logic next_link_up_latched;
  logic [31:0] dead_count;
  logic [31:0] next_dead_count;
  logic rst_busy;
  logic rst_done;
  logic rst_start;

  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready = !w_held && !o_bvalid;
  assign o_arready = !o_rvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = o_bvalid;
    next_bresp = o_bresp;
    if (i_awvalid && o_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_w_held = 1'b1;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end
    do_write = aw_held && w_held && !o_bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr == basic_mode_control_off || aw_addr == reset_time_off ||
                    aw_addr == link_status_off || aw_addr == event_status_off ||
                    aw_addr == fixed_info_off) ? resp_okay : resp_slverr;
    end else if (o_bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_comb begin
    do_read = i_arvalid && o_arready;
    next_rvalid = o_rvalid;
    next_rdata = o_rdata;
    next_rresp = o_rresp;
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp = resp_okay;
      case (i_araddr)
        basic_mode_control_off: next_rdata = {16'h0000, control};
        link_status_off: next_rdata = {30'h0, rst_busy, o_loopback_settling};
        event_status_off: next_rdata = {22'h0, link_up_latched, link_fail_latched, rx_err_count};
        fixed_info_off: next_rdata = {16'h0000, fixed_info_value};
        reset_time_off: next_rdata = {16'h0000, reset_len};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = resp_slverr;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // control and status next values
  // ------------------------------------------------------------
  logic [31:0] wr_merged;
  logic [31:0] rt_merged;
  logic event_read;
  always_comb begin
    wr_merged = merge({16'h0000, control}, w_data, w_strb);
    rt_merged = merge({16'h0000, reset_len}, w_data, w_strb);
    event_read = do_read && i_araddr == event_status_off;
    next_control = control;
    next_strap_age = (strap_age == 2'd3) ? strap_age : strap_age + 2'd1;
    next_reset_len = reset_len;
    rst_start = 1'b0;
    // straps need two edges through the synchronisers before they are loaded
    if (strap_age == 2'd2 || rst_done) begin
      next_control = 16'h0000;
      next_control[speed_bit] = strap_speed_s;
      next_control[autoneg_bit] = strap_autoneg_s;
      next_control[duplex_bit] = strap_duplex_s;
    end else if (do_write && aw_addr == basic_mode_control_off && !rst_busy) begin
      next_control = (wr_merged[15:0] & control_write_mask) | (control & ~control_write_mask);
      if (wr_merged[sw_reset_bit]) begin
        next_control[sw_reset_bit] = 1'b1;
        rst_start = 1'b1;
      end
    end
    // a zero length is ignored so the timer can never stall
    if (do_write && aw_addr == reset_time_off && rt_merged[15:0] != 16'h0000) begin
      next_reset_len = rt_merged[15:0];
    end
    // counter: read returns old value, clears, but a same-cycle error still counts
    next_rx_err_count = event_read ? 8'h00 : rx_err_count;
    if (i_rx_err_pulse && next_rx_err_count != 8'hff) begin
      next_rx_err_count = next_rx_err_count + 8'h01;
    end
    next_link_fail_latched = (event_read ? 1'b0 : link_fail_latched) | !i_link_ok;
    next_link_up_latched = (event_read ? i_link_ok : link_up_latched) & i_link_ok;
    // dead time after loopback rises; status only, the link partner waits it out
    next_dead_count = dead_count;
    if (next_control[loopback_bit] && !control[loopback_bit]) begin
      next_dead_count = loopback_dead_cycles;
    end else if (!control[loopback_bit]) begin
      next_dead_count = 32'h0;
    end else if (dead_count != 32'h0) begin
      next_dead_count = dead_count - 32'h1;
    end
  end

  assign o_loopback_settling = dead_count != 32'h0;

  reset_timer u_reset_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_start(rst_start),
    .i_cycles(reset_len),
    .o_busy(rst_busy),
    .o_done(rst_done)
  );

  // ------------------------------------------------------------
  // mode outputs and mii path
  // ------------------------------------------------------------
  logic [3:0] next_rxd;
  logic next_rx_dv;
  always_comb begin
    if (control[loopback_bit]) begin
      next_rxd = i_mii_txd;
      next_rx_dv = i_mii_tx_en;
    end else if (control[power_down_bit]) begin
      next_rxd = 4'h0;
      next_rx_dv = 1'b0;
    end else begin
      next_rxd = i_line_rxd;
      next_rx_dv = i_line_rx_dv;
    end
  end

  // speed and duplex fixed by negotiation when it is on (defaults shown here)
  assign o_speed_100 = control[autoneg_bit] ? 1'b1 : control[speed_bit];
  assign o_full_duplex = control[autoneg_bit] ? 1'b1 : control[duplex_bit];
  assign o_autoneg_en = control[autoneg_bit];
  assign o_power_down = control[power_down_bit];
  assign o_core_reset = rst_busy;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'b00;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= 2'b00;
      control <= 16'h0000;
      strap_age <= 2'd0;
      reset_len <= sw_reset_cycles;
      rx_err_count <= 8'h00;
      link_fail_latched <= 1'b0;
      link_up_latched <= 1'b0;
      dead_count <= 32'h0;
      o_mii_rxd <= 4'h0;
      o_mii_rx_dv <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      o_bvalid <= next_bvalid;
      o_bresp <= next_bresp;
      o_rvalid <= next_rvalid;
      o_rdata <= next_rdata;
      o_rresp <= next_rresp;
      control <= next_control;
      strap_age <= next_strap_age;
      reset_len <= next_reset_len;
      rx_err_count <= next_rx_err_count;
      link_fail_latched <= next_link_fail_latched;
      link_up_latched <= next_link_up_latched;
      dead_count <= next_dead_count;
      o_mii_rxd <= next_rxd;
      o_mii_rx_dv <= next_rx_dv;
    end
  end
endmodule : basic_mode_control_reg

/* File: basic_mode_control_assertions.sv */
// checker: bus handshake and mode output properties of the control bank
`timescale 1ns/1ps
module basic_mode_control_assertions
  import mode_ctrl_pkg::*;
(
  // clock and reset
  input wire logic i_clk, i_nrst,
  // register bus
  input wire logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready,
  input wire logic i_arvalid, o_arready, o_rvalid, i_rready,
  input wire logic [1:0] o_bresp, o_rresp,
  input wire logic [31:0] o_rdata,
  // mii and mode
  input wire logic [3:0] i_mii_txd, o_mii_rxd,
  input wire logic o_loopback_settling, o_autoneg_en, o_speed_100, o_full_duplex,
  input wire logic o_core_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ------------------------------------------------------------
  // bus
  // ------------------------------------------------------------
  sequence wr_pair;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence rd_take;
    i_arvalid && o_arready;
  endsequence
  a_write_answer: assert property (wr_pair |-> ##2 o_bvalid)
    else $error("no write response two cycles after address and data");
  a_read_answer: assert property (rd_take |=> o_rvalid)
    else $error("no read data one cycle after read address");
  a_write_blocks: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write channels open while response pending");
  a_read_blocks: assert property (o_rvalid |-> !o_arready)
    else $error("read address open while data pending");
  a_error_zero: assert property (o_rvalid && o_rresp == resp_slverr |-> o_rdata == 32'h0)
    else $error("refused read carries data");
  // ------------------------------------------------------------
  // mode
  // ------------------------------------------------------------
  a_loop_route: assert property ($past(o_loopback_settling) && o_loopback_settling
    |-> o_mii_rxd == $past(i_mii_txd))
    else $error("loopback does not return transmit data");
  a_an_ignores: assert property (o_autoneg_en |-> o_speed_100 && o_full_duplex)
    else $error("forced speed or duplex leaks through with autoneg on");
  // short reset counts would hide a timer that never runs
  a_reset_stretch: assert property ($rose(o_core_reset) |-> o_core_reset [*8])
    else $error("software reset ended too early");
endmodule : basic_mode_control_assertions

bind basic_mode_control_reg basic_mode_control_assertions u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_bresp(o_bresp), .o_rresp(o_rresp), .o_rdata(o_rdata), .i_mii_txd(i_mii_txd),
  .o_mii_rxd(o_mii_rxd), .o_loopback_settling(o_loopback_settling),
  .o_autoneg_en(o_autoneg_en), .o_speed_100(o_speed_100),
  .o_full_duplex(o_full_duplex), .o_core_reset(o_core_reset)
);

/* File: phy_core_model.sv */
// partner: phy core side, status events and mii data
`timescale 1ns/1ps
module phy_core_model (
  // clock
  input wire logic i_clk,
  // one fault event request
  input wire logic i_event,
  // toward the register bank
  output logic o_rx_err_pulse,
  output logic o_link_ok,
  output logic [3:0] o_mii_txd,
  output logic o_mii_tx_en,
  output logic [3:0] o_line_rxd,
  output logic o_line_rx_dv
);
  logic [3:0] cnt = 4'h0;
  initial begin
    o_rx_err_pulse = 1'b0;
    o_link_ok = 1'b1;
  end
  // data moves every cycle so a stale or wrong path cannot match
  always @(posedge i_clk) begin
    cnt <= cnt + 4'h1;
    o_rx_err_pulse <= i_event;
    o_link_ok <= !i_event;
  end
  assign o_mii_txd = cnt;
  assign o_mii_tx_en = cnt[0];
  assign o_line_rxd = ~cnt;
  assign o_line_rx_dv = !cnt[0];
endmodule : phy_core_model

/* File: testbench.sv */
// testbench: register bus sequences against the control bank
`timescale 1ns/1ps
module testbench;
  import mode_ctrl_pkg::*;
  logic i_clk = 0, i_nrst = 0, awvalid = 0, wvalid = 0, arvalid = 0, ev = 0;
  logic bready = 1, rready = 1, st_speed = 1, st_an = 0, st_dup = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 4'hf, txd, line_rxd, rxd, v;
  logic awready, wready, bvalid, arready, rvalid, err_p, link_ok, tx_en, line_dv, rx_dv;
  logic sp100, fdx, an_en, pdn, core_rst, settling;
  logic [1:0] bresp, rresp, r;
  int err_total = 0, checks = 0;
  always #2 i_clk = ~i_clk;
  // ------------------------------------------------------------
  // design and partner
  // ------------------------------------------------------------
  basic_mode_control_reg i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_strap_speed(st_speed),
    .i_strap_autoneg(st_an), .i_strap_duplex(st_dup), .i_rx_err_pulse(err_p),
    .i_link_ok(link_ok), .i_mii_txd(txd), .i_mii_tx_en(tx_en), .i_line_rxd(line_rxd),
    .i_line_rx_dv(line_dv), .o_mii_rxd(rxd), .o_mii_rx_dv(rx_dv), .o_speed_100(sp100),
    .o_full_duplex(fdx), .o_autoneg_en(an_en), .o_power_down(pdn),
    .o_core_reset(core_rst), .o_loopback_settling(settling));
  phy_core_model i_phy (.i_clk(i_clk), .i_event(ev), .o_rx_err_pulse(err_p),
    .o_link_ok(link_ok), .o_mii_txd(txd), .o_mii_tx_en(tx_en), .o_line_rxd(line_rxd),
    .o_line_rx_dv(line_dv));
  // ------------------------------------------------------------
  // tasks, entered and left just after a rising edge
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] dat);
    logic aw_t, w_t, da, dw;
    da = 0;
    dw = 0;
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= dat;
    while (!(da && dw)) begin
      @(negedge i_clk);
      aw_t = !da && awready;
      w_t = !dw && wready;
      @(posedge i_clk);
      if (aw_t) awvalid <= 0;
      if (w_t) wvalid <= 0;
      da = da | aw_t;
      dw = dw | w_t;
    end
    do @(negedge i_clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    arvalid <= 1;
    araddr <= a;
    do @(negedge i_clk); while (arready !== 1'b1);
    @(posedge i_clk);
    arvalid <= 0;
    do @(negedge i_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge i_clk);
  endtask : rd
  task automatic path(input logic lb);
    logic vdv;
    #1;
    v = lb ? txd : line_rxd;
    vdv = lb ? tx_en : line_dv;
    @(posedge i_clk);
    #1;
    chk({27'h0, rx_dv, rxd}, {27'h0, vdv, v});
    @(posedge i_clk);
  endtask : path
  task automatic conclude();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    #40000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1;
    repeat (3) @(posedge i_clk);
    rd(basic_mode_control_off);
    chk(d & 32'hc800, 32'h0);
    chk(d, 32'h2100);
    rd(fixed_info_off);
    chk(d, 32'h0a5c);
    wr(fixed_info_off, 32'hffff);
    chk({30'h0, r}, {30'h0, resp_okay});
    rd(fixed_info_off);
    chk(d, 32'h0a5c);
    wr(reset_time_off, 32'd20);
    wr(basic_mode_control_off, 32'h2100);
    rd(basic_mode_control_off);
    chk(d, 32'h2100);
    chk({29'h0, an_en, sp100, fdx}, 32'h3);
    wr(basic_mode_control_off, 32'h0);
    chk({29'h0, an_en, sp100, fdx}, 32'h0);
    wr(basic_mode_control_off, 32'h1000);
    chk({29'h0, an_en, sp100, fdx}, 32'h7);
    // only the low lane is strobed, so the upper control byte must survive
    wstrb <= 4'h1;
    wr(basic_mode_control_off, 32'hffff);
    wstrb <= 4'hf;
    rd(basic_mode_control_off);
    chk(d, 32'h1000);
    wr(basic_mode_control_off, 32'h0800);
    chk({31'h0, pdn}, 32'h1);
    @(negedge i_clk);
    chk({27'h0, rx_dv, rxd}, 32'h0);
    @(posedge i_clk);
    wr(basic_mode_control_off, 32'h4000);
    rd(basic_mode_control_off);
    chk(d, 32'h4000);
    chk({31'h0, settling}, 32'h1);
    path(1'b1);
    wr(basic_mode_control_off, 32'h0);
    path(1'b0);
    wr(basic_mode_control_off, 32'h8000);
    rd(basic_mode_control_off);
    chk(d & 32'h8000, 32'h8000);
    rd(link_status_off);
    chk(d & 32'h2, 32'h2);
    // the control word is reloaded one edge after the core reset drops
    do @(negedge i_clk); while (core_rst !== 1'b0);
    @(posedge i_clk);
    rd(basic_mode_control_off);
    chk(d, 32'h2100);
    rd(link_status_off);
    chk(d & 32'h2, 32'h0);
    rd(event_status_off);
    repeat (3) begin
      ev <= 1;
      @(posedge i_clk);
      ev <= 0;
      repeat (2) @(posedge i_clk);
    end
    rd(event_status_off);
    chk(d, 32'h103);
    rd(event_status_off);
    chk(d, 32'h200);
    rd(12'h020);
    chk({r, d[29:0]}, {resp_slverr, 30'h0});
    wr(12'h020, 32'h1);
    chk({30'h0, r}, {30'h0, resp_slverr});
    conclude();
  end
endmodule : testbench
